// ===== src/ceti_pkg.sv
// Purpose: shared constants for the 8-bit carrier/interval timer
// Assumes: byte-wide register port, 16-bit addresses, peripheral clock = clk
// Notes: compare and port-latch offsets sit beside the documented ones
package ceti_pkg;

	// register map
	localparam logic [15:0] MODE_CTRL_OFFSET = 16'hFF6C;
	localparam logic [15:0] CARRIER_CTRL_OFFSET = 16'hFF6D;
	localparam logic [15:0] PORT_DIR_OFFSET = 16'hFF21;
	localparam logic [15:0] PORT_LATCH_OFFSET = 16'hFF01;
	localparam logic [15:0] FIRST_CMP_OFFSET = 16'hFF18;
	localparam logic [15:0] SECOND_CMP_OFFSET = 16'hFF19;

	// reset values
	localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
	localparam logic [7:0] CARRIER_CTRL_RESET = 8'h00;
	localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
	localparam logic [7:0] PORT_LATCH_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// mode register fields
	localparam int RUN_ENABLE_BIT = 7;
	localparam int CLK_SEL_LSB = 4;
	localparam int MODE_SEL_LSB = 2;
	localparam int DEFAULT_LEVEL_BIT = 1;
	localparam int OUTPUT_ENABLE_BIT = 0;

	// carrier control fields
	localparam int CARRIER_ENABLE_BIT = 2;
	localparam int PENDING_LEVEL_BIT = 1;
	localparam int CARRIER_STATUS_BIT = 0;

	// pin served by this timer inside the port
	localparam int PIN_DIRECTION_BIT = 6;

	// prescaler: log2 of each division ratio
	localparam int PRESC_W = 12;
	localparam int RL_W = 9;
	localparam int DIV_LOG_P1 = 0;
	localparam int DIV_LOG_P4 = 2;
	localparam int DIV_LOG_P16 = 4;
	localparam int DIV_LOG_P64 = 6;
	localparam int DIV_LOG_P4096 = 12;
	localparam int DIV_LOG_RL128 = 7;
	localparam int DIV_LOG_RL512 = 9;
	localparam int DIV_LOG_RL1 = 0;

	localparam logic [2:0] CLK_SEL_RL128 = 3'h5;

	typedef enum logic [1:0] {
		CETI_MODE_INTERVAL = 2'h0,
		CETI_MODE_CARRIER = 2'h1,
		CETI_MODE_PWM = 2'h2,
		CETI_MODE_PROHIBITED = 2'h3
	} ceti_mode_e;

endpackage : ceti_pkg

// ===== src/ceti_count_clock.sv
// Purpose: count-clock enable generator for the carrier/interval timer
// Assumes: clk is the peripheral clock; the low-speed oscillator is asynchronous
// Notes: emits a one-cycle tick per selected count-clock rising edge
`timescale 1ns/1ns
`default_nettype none

module ceti_count_clock
	import ceti_pkg::*;
#(
	parameter int PRESC_BITS = PRESC_W,
	parameter int RL_BITS = RL_W
) (
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// source selection
	input wire logic [2:0] clock_select,
	input wire logic low_speed_osc_clock,
	// count clock enable
	output logic count_tick
);

	if (PRESC_BITS < DIV_LOG_P4096) begin : g_chk_presc
		$error("prescaler too narrow for the largest division");
	end
	if (RL_BITS < DIV_LOG_RL512) begin : g_chk_rl
		$error("low-speed divider too narrow");
	end

	logic [PRESC_BITS-1:0] presc;
	logic [PRESC_BITS-1:0] next_presc;
	logic [RL_BITS-1:0] rl_cnt;
	logic [RL_BITS-1:0] next_rl_cnt;
	logic rl_meta;
	logic rl_sync;
	logic rl_prev;
	logic next_tick;

	// true when the low bits selected by log2 are all ones
	function automatic logic at_wrap(input logic [PRESC_BITS-1:0] v, input int lg);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < PRESC_BITS; i++) begin
			if (i < lg && !v[i]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : at_wrap

	always_comb begin
		logic rl_edge;
		logic [PRESC_BITS-1:0] rl_wide;
		rl_edge = rl_sync & ~rl_prev;
		rl_wide = PRESC_BITS'(rl_cnt);
		next_presc = presc + 1'b1;
		next_rl_cnt = rl_edge ? rl_cnt + 1'b1 : rl_cnt;
		case (clock_select) // [RULE2]
			3'h0: next_tick = at_wrap(presc, DIV_LOG_P1);
			3'h1: next_tick = at_wrap(presc, DIV_LOG_P4);
			3'h2: next_tick = at_wrap(presc, DIV_LOG_P16);
			3'h3: next_tick = at_wrap(presc, DIV_LOG_P64);
			3'h4: next_tick = at_wrap(presc, DIV_LOG_P4096);
			3'h5: next_tick = rl_edge && at_wrap(rl_wide, DIV_LOG_RL128);
			3'h6: next_tick = rl_edge && at_wrap(rl_wide, DIV_LOG_RL512);
			3'h7: next_tick = rl_edge && at_wrap(rl_wide, DIV_LOG_RL1);
			default: next_tick = 1'b0;
		endcase
	end

	// the oscillator is foreign to clk: two flops before the edge detector
	always_ff @(posedge clk) begin
		if (srst) begin
			presc <= '0;
			rl_cnt <= '0;
			rl_meta <= 1'b0;
			rl_sync <= 1'b0;
			rl_prev <= 1'b0;
			count_tick <= 1'b0;
		end else if (ce) begin
			presc <= next_presc;
			rl_cnt <= next_rl_cnt;
			rl_meta <= low_speed_osc_clock;
			rl_sync <= rl_meta;
			rl_prev <= rl_sync;
			count_tick <= next_tick;
		end
	end

endmodule : ceti_count_clock

`default_nettype wire

// ===== src/ceti_timer.sv
// Purpose: 8-bit up-counting timer with interval, PWM and carrier modes
// Assumes: byte register port with strobes; companion event on the clk domain
// Notes: the prescaler runs freely, so start and stop land on any phase
// How it works
// RULE1: run-enable low stops the timer and clears the counter; high counts.
// RULE2: clock code picks peripheral clock /1,/4,/16,/64,/4096 or slow osc /128,/512,/1.
// RULE3: mode code 00 interval, 01 carrier, 10 PWM, 11 not allowed.
// RULE4: level bit sets idle output level; output-enable bit gates the output.
// RULE5: software leaves mode bits alone while running, except same-value rewrites.
// RULE6: PWM and carrier restarts need a fresh second-compare write first.
// RULE7: in carrier mode this count clock exceeds six times the companion's.
// RULE8: carrier enable and pending level choose low, high, or carrier pulses.
// RULE9: read-only status bit 0 reports whether the carrier output is active.
// RULE10: software leaves carrier enable alone while the timer runs.
// RULE11: software clears pin direction and latch to route the timer out.
// RULE12: interval mode match on first compare interrupts and clears the counter.
// RULE13: interval mode ignores the second compare register completely.
// RULE14: interval period is first compare plus one count clocks.
// RULE15: interval mode toggles the output each match for a 50 percent square wave.
// RULE16: counting begins within one count clock after run-enable is set.
// RULE17: the match interrupt comes with the selected count clock edge.
// RULE18: stopping returns interrupt and output to their default levels; in carrier mode the code drives the pin from the status bit.
// RULE19: first compare is written only while stopped.
// RULE20: companion event is synced to the count clock and loads the status bit.
// RULE21: counter is 8 bits, steps by one per tick, compared on every tick.
`timescale 1ns/1ns
`default_nettype none

module ceti_timer
	import ceti_pkg::*;
#(
	parameter int COUNT_W = 8
) (
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// register port
	input wire logic [15:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// clock sources and companion timer
	input wire logic low_speed_osc_clock,
	input wire logic companion_timer_event,
	// timer outputs
	output logic match_interrupt,
	output logic carrier_output_pin_out,
	output logic carrier_output_pin_oe
);

	if (COUNT_W != 8) begin : g_chk_width
		$error("counter width must be 8 to match the byte registers");
	end

	logic [7:0] mode_ctrl;
	logic [7:0] next_mode_ctrl;
	logic carrier_enable;
	logic next_carrier_enable;
	logic pending_level;
	logic next_pending_level;
	logic carrier_status;
	logic next_carrier_status;
	logic [7:0] port_direction;
	logic [7:0] next_port_direction;
	logic [7:0] port_latch;
	logic [7:0] next_port_latch;
	logic [7:0] first_compare;
	logic [7:0] next_first_compare;
	logic [7:0] second_compare_reg;
	logic [7:0] next_second_compare_reg;
	logic [7:0] second_compare_buf;
	logic [7:0] next_second_compare_buf;
	logic second_buf_full;
	logic next_second_buf_full;
	logic [COUNT_W-1:0] counter;
	logic [COUNT_W-1:0] next_counter;
	logic use_second;
	logic next_use_second;
	logic started;
	logic next_started;
	logic level;
	logic next_level;
	logic event_prev;
	logic event_pending;
	logic next_event_pending;
	logic next_irq;
	logic next_pin_out;
	logic next_pin_oe;
	logic [7:0] next_rdata;
	logic count_tick;

	logic run_enable;
	logic default_output_level;
	logic output_enable;
	ceti_mode_e mode;

	assign run_enable = mode_ctrl[RUN_ENABLE_BIT];
	assign default_output_level = mode_ctrl[DEFAULT_LEVEL_BIT];
	assign output_enable = mode_ctrl[OUTPUT_ENABLE_BIT];
	assign mode = ceti_mode_e'(mode_ctrl[MODE_SEL_LSB +: 2]); // [RULE3]

	ceti_count_clock #(
		.PRESC_BITS(PRESC_W),
		.RL_BITS(RL_W)
	) u_count_clock (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.clock_select(mode_ctrl[CLK_SEL_LSB +: 3]), // [RULE2]
		.low_speed_osc_clock(low_speed_osc_clock),
		.count_tick(count_tick)
	);

	// register writes and reads
	always_comb begin
		next_mode_ctrl = mode_ctrl;
		next_carrier_enable = carrier_enable;
		next_pending_level = pending_level;
		next_port_direction = port_direction;
		next_port_latch = port_latch;
		next_first_compare = first_compare;
		next_rdata = rdata;
		if (wr_en) begin
			case (addr)
				// mode bits are not guarded against running writes [RULE5]
				MODE_CTRL_OFFSET: next_mode_ctrl = wdata;
				CARRIER_CTRL_OFFSET: begin
					next_carrier_enable = wdata[CARRIER_ENABLE_BIT]; // [RULE10]
					next_pending_level = wdata[PENDING_LEVEL_BIT];
				end
				PORT_DIR_OFFSET: next_port_direction = wdata; // [RULE11]
				PORT_LATCH_OFFSET: next_port_latch = wdata;
				// software writes this only while stopped [RULE19]
				FIRST_CMP_OFFSET: next_first_compare = wdata;
				default: ;
			endcase
		end
		if (rd_en) begin
			case (addr)
				MODE_CTRL_OFFSET: next_rdata = mode_ctrl;
				CARRIER_CTRL_OFFSET: next_rdata = {5'h00, carrier_enable, pending_level,
					carrier_status}; // [RULE9]
				PORT_DIR_OFFSET: next_rdata = port_direction;
				PORT_LATCH_OFFSET: next_rdata = port_latch;
				FIRST_CMP_OFFSET: next_rdata = first_compare;
				SECOND_CMP_OFFSET: next_rdata = second_buf_full ? second_compare_buf
					: second_compare_reg;
				default: next_rdata = UNMAPPED_READ;
			endcase
		end
	end

	// counter, compare sequencing, output level and interrupt
	always_comb begin
		logic hit;
		logic wr_second;
		logic take_buf;
		hit = 1'b0;
		take_buf = 1'b0;
		wr_second = wr_en && (addr == SECOND_CMP_OFFSET);
		next_counter = counter;
		next_use_second = use_second;
		next_started = started;
		next_level = level;
		next_irq = 1'b0;
		next_second_compare_reg = second_compare_reg;
		next_second_compare_buf = second_compare_buf;
		next_second_buf_full = second_buf_full;
		if (!run_enable) begin
			// stopped: counter cleared, output back to idle level [RULE1] [RULE18]
			next_counter = '0;
			next_use_second = 1'b0;
			next_started = 1'b0;
			next_level = default_output_level; // [RULE4]
			next_second_buf_full = 1'b0;
		end else if (count_tick) begin // [RULE17]
			if (!started) begin
				// first count clock is masked, counting from the next [RULE16]
				next_started = 1'b1;
			end else begin
				// interval mode never selects the second register [RULE13] [RULE21]
				hit = (counter == (use_second ? second_compare_reg : first_compare));
				if (!hit) begin
					next_counter = counter + 1'b1; // [RULE21]
				end else begin
					case (mode)
						CETI_MODE_INTERVAL: begin
							// clear at N gives N+1 ticks per period [RULE12] [RULE14]
							next_counter = '0;
							next_irq = 1'b1;
							next_level = ~level; // [RULE15]
						end
						CETI_MODE_PWM: begin
							next_level = ~level;
							next_use_second = ~use_second;
							if (!use_second) begin
								next_counter = '0;
								next_irq = 1'b1;
							end else begin
								next_counter = counter + 1'b1;
								take_buf = 1'b1;
							end
						end
						CETI_MODE_CARRIER: begin
							// first compare sets low width, second the high width
							next_counter = '0;
							next_level = ~level;
							next_use_second = ~use_second;
							if (use_second) begin
								next_irq = 1'b1;
								take_buf = 1'b1;
							end
						end
						default: next_counter = counter;
					endcase
				end
			end
		end
		// running writes are held until the old value matches; a clash keeps the old
		if (wr_second) begin
			if (run_enable) begin
				next_second_compare_buf = wdata;
				next_second_buf_full = 1'b1;
			end else begin
				// a stopped write lands at once, so restarts see it [RULE6]
				next_second_compare_reg = wdata;
				next_second_compare_buf = wdata;
				next_second_buf_full = 1'b0;
			end
		end else if (take_buf && second_buf_full) begin
			next_second_compare_reg = second_compare_buf;
			next_second_buf_full = 1'b0;
		end
	end

	// companion event capture and carrier status transfer
	always_comb begin
		logic rise;
		rise = companion_timer_event & ~event_prev;
		next_event_pending = event_pending | rise;
		next_carrier_status = carrier_status;
		if (count_tick && event_pending) begin
			// synced companion event copies pending level into status [RULE20]
			next_carrier_status = next_pending_level;
			next_event_pending = rise;
		end
	end

	// pin drive computed from next state so the pin is registered
	always_comb begin
		logic timer_level;
		timer_level = next_level;
		if (next_mode_ctrl[MODE_SEL_LSB +: 2] == CETI_MODE_CARRIER) begin
			// status low: low; high: carrier pulses or steady high [RULE8] [RULE9]
			if (!next_carrier_status) begin
				timer_level = 1'b0;
			end else begin
				timer_level = next_carrier_enable ? next_level : 1'b1;
			end
		end
		if (!next_mode_ctrl[OUTPUT_ENABLE_BIT]) begin
			timer_level = next_mode_ctrl[DEFAULT_LEVEL_BIT]; // [RULE4]
		end
		// latch is ored in, so it must be cleared to pass the timer
		next_pin_out = timer_level | next_port_latch[PIN_DIRECTION_BIT]; // [RULE11]
		next_pin_oe = ~next_port_direction[PIN_DIRECTION_BIT];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mode_ctrl <= MODE_CTRL_RESET;
			carrier_enable <= CARRIER_CTRL_RESET[CARRIER_ENABLE_BIT];
			pending_level <= CARRIER_CTRL_RESET[PENDING_LEVEL_BIT];
			carrier_status <= CARRIER_CTRL_RESET[CARRIER_STATUS_BIT];
			port_direction <= PORT_DIR_RESET;
			port_latch <= PORT_LATCH_RESET;
			first_compare <= CMP_RESET;
			second_compare_reg <= CMP_RESET;
			second_compare_buf <= CMP_RESET;
			second_buf_full <= 1'b0;
			counter <= '0;
			use_second <= 1'b0;
			started <= 1'b0;
			level <= 1'b0;
			event_prev <= 1'b0;
			event_pending <= 1'b0;
			rdata <= UNMAPPED_READ;
			match_interrupt <= 1'b0;
			carrier_output_pin_out <= 1'b0;
			carrier_output_pin_oe <= 1'b0;
		end else if (ce) begin
			mode_ctrl <= next_mode_ctrl;
			carrier_enable <= next_carrier_enable;
			pending_level <= next_pending_level;
			carrier_status <= next_carrier_status;
			port_direction <= next_port_direction;
			port_latch <= next_port_latch;
			first_compare <= next_first_compare;
			second_compare_reg <= next_second_compare_reg;
			second_compare_buf <= next_second_compare_buf;
			second_buf_full <= next_second_buf_full;
			counter <= next_counter;
			use_second <= next_use_second;
			started <= next_started;
			level <= next_level;
			event_prev <= companion_timer_event;
			event_pending <= next_event_pending;
			rdata <= next_rdata;
			match_interrupt <= next_irq;
			carrier_output_pin_out <= next_pin_out;
			carrier_output_pin_oe <= next_pin_oe;
		end
	end

endmodule : ceti_timer

`default_nettype wire

// ===== tb/ceti_asserts.sv
// Purpose: port-level checks for the carrier/interval timer
// Assumes: ce held high; shadows follow register writes seen at the port
// Notes: period checks cover interval mode on the undivided clock only
`timescale 1ns/1ns
`default_nettype none

module ceti_asserts
	import ceti_pkg::*;
(
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// register port
	input wire logic [15:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	// timer outputs
	input wire logic match_interrupt,
	input wire logic carrier_output_pin_out,
	input wire logic carrier_output_pin_oe
);
	logic [7:0] mode;
	logic [7:0] cmp;
	logic lat;
	logic dir;
	logic seen;
	logic [15:0] gap;
	logic [15:0] since;
	wire wr = ce && wr_en;
	// interval mode on the undivided clock, where periods are exact
	wire fast = mode[7] && mode[6:2] == 5'h00;

	always_ff @(posedge clk) begin
		if (srst) begin
			mode <= MODE_CTRL_RESET;
			cmp <= CMP_RESET;
			lat <= 1'b0;
			dir <= 1'b1;
		end else if (wr) begin
			if (addr == MODE_CTRL_OFFSET) mode <= wdata;
			if (addr == FIRST_CMP_OFFSET) cmp <= wdata;
			if (addr == PORT_LATCH_OFFSET) lat <= wdata[PIN_DIRECTION_BIT];
			if (addr == PORT_DIR_OFFSET) dir <= wdata[PIN_DIRECTION_BIT];
		end
	end

	always_ff @(posedge clk) begin
		gap <= (srst || match_interrupt) ? 16'h0000 : gap + 16'h0001;
		since <= (srst || !mode[7]) ? 16'h0000 : since + 16'h0001;
		seen <= (srst || !mode[7]) ? 1'b0 : (seen || match_interrupt);
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_oe_dir;
		$stable(dir) |-> carrier_output_pin_oe == !dir;
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("pin enable does not follow direction");

	property p_stop_quiet;
		!mode[7] && !$past(mode[7]) |-> !match_interrupt;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("interrupt while stopped");

	property p_stop_level;
		!mode[7] && !$past(mode[7]) && mode[3:2] != 2'h1 && $stable(mode) && $stable(lat)
			|-> carrier_output_pin_out == (mode[1] | lat);
	endproperty
	a_stop_level: assert property (p_stop_level) else $error("stopped pin not at idle level");

	property p_period;
		match_interrupt && seen && fast |-> gap == {8'h00, cmp};
	endproperty
	a_period: assert property (p_period) else $error("interval period wrong");

	property p_bound;
		fast |-> (seen ? gap <= {8'h00, cmp} : since <= {8'h00, cmp} + 16'h0004);
	endproperty
	a_bound: assert property (p_bound) else $error("match interrupt late");

	property p_toggle;
		match_interrupt && fast && mode[0] && !lat
			|-> carrier_output_pin_out != $past(carrier_output_pin_out);
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");

	property p_hold;
		fast && $past(mode[7]) && mode[0] && !lat && $stable(lat) && !match_interrupt
			|-> $stable(carrier_output_pin_out);
	endproperty
	a_hold: assert property (p_hold) else $error("pin moved between matches");

	property p_status_ro;
		rd_en && ce && addr == CARRIER_CTRL_OFFSET |=> rdata[7:3] == 5'h00;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("carrier control upper bits set");

	c_irq: cover property (match_interrupt && fast && seen);
	c_carrier: cover property (mode[3:2] == 2'h1 && $rose(carrier_output_pin_out));
	c_oe: cover property (carrier_output_pin_oe);

endmodule : ceti_asserts

`default_nettype wire

// ===== tb/ceti_partner.sv
// Purpose: companion interval timer event and slow oscillator for the bench
// Assumes: fire is a one-cycle request from the bench
// Notes: the oscillator period is chosen off the clk grid on purpose
`timescale 1ns/1ns
`default_nettype none

module ceti_partner (
	// clocking and request
	input wire logic clk,
	input wire logic fire,
	// toward the timer
	output logic companion_timer_event,
	output logic low_speed_osc_clock
);
	logic req;
	int left;

	initial begin
		low_speed_osc_clock = 1'b0;
		forever #73 low_speed_osc_clock = ~low_speed_osc_clock;
	end

	initial begin
		companion_timer_event = 1'b0;
		req = 1'b0;
		left = 0;
	end

	always @(posedge clk) req <= fire;

	// companion counts eight times slower, so one event spans eight cycles
	always @(negedge clk) begin
		if (req) left = 8;
		else if (left > 0) left--;
		companion_timer_event = (left > 0);
	end

endmodule : ceti_partner

`default_nettype wire

// ===== tb/ceti_timer_bench.sv
// Purpose: self-checking bench for the carrier/interval timer
// Assumes: inputs change on the falling edge; ce stays high
// Notes: slow-oscillator codes are only checked for producing matches
`timescale 1ns/1ns
`default_nettype none

module ceti_timer_bench;
	import ceti_pkg::*;
	logic clk, srst, ce, wr_en, rd_en, fire, ev, osc, irq, pin, oe;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, d, cur;
	int fails, checked, cyc, n;

	ceti_timer u_dut (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wr_en(wr_en),
		.rd_en(rd_en), .wdata(wdata), .rdata(rdata), .low_speed_osc_clock(osc),
		.companion_timer_event(ev), .match_interrupt(irq), .carrier_output_pin_out(pin),
		.carrier_output_pin_oe(oe));
	ceti_partner u_far (.clk(clk), .fire(fire), .companion_timer_event(ev),
		.low_speed_osc_clock(osc));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task wrap_up;
		if (fails == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end

	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge clk);
		addr = a;
		wdata = v;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr

	task rd(input logic [15:0] a);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd

	// cycles until the next interrupt pulse, bounded
	task gap;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (irq !== 1'b1 && n < 20000);
	endtask : gap

	task halt;
		cur = cur & 8'h7F;
		wr(MODE_CTRL_OFFSET, cur);
	endtask : halt

	task run(input logic [7:0] m, input logic [7:0] c0, input logic [7:0] c1);
		halt();
		wr(MODE_CTRL_OFFSET, m);
		wr(FIRST_CMP_OFFSET, c0);
		wr(SECOND_CMP_OFFSET, c1);
		cur = m | 8'h80;
		wr(MODE_CTRL_OFFSET, cur);
	endtask : run

	task count_irq(input int len);
		n = 0;
		repeat (len) begin
			@(negedge clk);
			if (irq === 1'b1) n++;
		end
	endtask : count_irq

	task pulse_event;
		@(negedge clk);
		fire = 1'b1;
		@(negedge clk);
		fire = 1'b0;
		repeat (20) @(negedge clk);
	endtask : pulse_event

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		fire = 1'b0;
		cur = 8'h00;
		fails = 0;
		checked = 0;
		cyc = 0;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		chk("oe after reset", oe, 16'h0000);
		rd(MODE_CTRL_OFFSET);
		chk("mode reset", d, MODE_CTRL_RESET);
		rd(CARRIER_CTRL_OFFSET);
		chk("carrier reset", d, CARRIER_CTRL_RESET);
		rd(PORT_DIR_OFFSET);
		chk("direction reset", d, 16'h00FF);
		rd(16'hFFFF);
		chk("unmapped read", d, UNMAPPED_READ);
		wr(CARRIER_CTRL_OFFSET, 8'hFF);
		rd(CARRIER_CTRL_OFFSET);
		chk("carrier writable bits", d, 16'h0006);
		wr(CARRIER_CTRL_OFFSET, 8'h00);
		wr(PORT_DIR_OFFSET, 8'hBF);
		wr(PORT_LATCH_OFFSET, 8'h00);
		repeat (2) @(negedge clk);
		chk("oe driving", oe, 16'h0001);
		// square wave, second compare set but unused in this mode
		run(8'h01, 8'h04, 8'h01);
		gap();
		count_irq(50);
		chk("interval pulses", 16'(n), 16'd10);
		for (int k = 0; k < 5; k++) begin
			run({1'b0, 3'(k), 4'h1}, 8'h01, 8'h00);
			gap();
			gap();
			chk("divided period", 16'(n), 16'(2 << (k == 4 ? 12 : 2 * k)));
		end
		for (int k = 5; k < 8; k++) begin
			run({1'b0, 3'(k), 4'h1}, 8'h00, 8'h00);
			gap();
			chk("slow clock matches", 16'(n < 20000), 16'h0001);
		end
		run(8'h03, 8'h02, 8'h00);
		gap();
		halt();
		repeat (2) @(negedge clk);
		chk("idle level high", pin, 16'h0001);
		chk("irq idle", irq, 16'h0000);
		run(8'h0C, 8'h01, 8'h00);
		count_irq(40);
		chk("prohibited mode pulses", 16'(n), 16'h0000);
		run(8'h09, 8'h05, 8'h02);
		gap();
		gap();
		chk("pwm period", 16'(n), 16'd6);
		halt();
		wr(CARRIER_CTRL_OFFSET, 8'h02);
		run(8'h05, 8'h03, 8'h01);
		pulse_event();
		chk("carrier off level", pin, 16'h0001);
		rd(CARRIER_CTRL_OFFSET);
		chk("status loaded", d, 16'h0003);
		gap();
		gap();
		chk("carrier period", 16'(n), 16'd6);
		halt();
		wr(CARRIER_CTRL_OFFSET, 8'h06);
		run(8'h05, 8'h03, 8'h01);
		pulse_event();
		n = 0;
		repeat (30) begin
			d[0] = pin;
			@(negedge clk);
			if (pin === 1'b1 && d[0] === 1'b0) n++;
		end
		chk("carrier pulses", 16'(n), 16'd5);
		wr(CARRIER_CTRL_OFFSET, 8'h04);
		pulse_event();
		chk("carrier stopped low", pin, 16'h0000);
		rd(CARRIER_CTRL_OFFSET);
		chk("status cleared", d, 16'h0004);
		halt();
		wrap_up();
	end

endmodule : ceti_timer_bench

bind ceti_timer ceti_asserts u_chk (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
	.wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
	.match_interrupt(match_interrupt), .carrier_output_pin_out(carrier_output_pin_out),
	.carrier_output_pin_oe(carrier_output_pin_oe));

`default_nettype wire
